// *** verilog/boot_mode_config_loader.sv ***
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "boot_loader_defs.svh"

// Behaviour
// - Sample mode pins only after power-up
// - System reset reuses stored boot mode
// - Copy loader from selected source to memory
// - Finally hand execution to loaded loader
// - System setup, optional fabric, then application
// - Three sources chosen by jumper pin pair
// - Debug boot stalls until host loads
// - Host configures fabric without the processor
// - Default cascaded chain shows both parts
// - Split jumper leaves only fabric on chain
// - Jumper change needs full power cycle
// - System reset clears memories, keeps mode
module boot_mode_config_loader #(
  parameter int  OCM_BYTES = `OCM_BYTES_DEFAULT,
  parameter int  ADDR_W    = 16,
  parameter logic [31:0] MARKER = `MARKER_DEFAULT
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [2:0]        mode_jumper,
  input  wire logic              chain_split_jumper,
  input  wire logic              system_soft_reset,
  output logic [1:0]             src_sel,
  output logic                   src_req,
  output logic [ADDR_W-1:0]      src_addr,
  input  wire logic              src_rvalid,
  input  wire logic [31:0]       src_rdata,
  output logic                   ocm_we,
  output logic [ADDR_W-1:0]      ocm_addr,
  output logic [31:0]            ocm_wdata,
  output logic                   ocm_clear,
  output logic                   fabric_clear,
  output logic                   handoff,
  output logic                   core_run,
  output logic                   core_step,
  output logic                   ps_init_req,
  input  wire logic              ps_init_done,
  output logic                   fabric_cfg_req,
  input  wire logic              fabric_cfg_done,
  output logic                   app_load_req,
  input  wire logic              app_load_done,
  output logic                   app_start,
  output logic                   ps_on_scan_chain,
  output logic                   fabric_on_scan_chain,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);
  import boot_loader_pkg::*;

  localparam int OCM_WORDS = OCM_BYTES / 4;

  initial begin
    if (OCM_WORDS > (1 << ADDR_W) || OCM_BYTES < 16) begin
      $error("Memory size does not fit the address width");
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  boot_state_e       state_reg, state_next;
  boot_src_e         boot_mode_reg;
  logic              split_reg;
  logic              error_reg;
  logic              bitstream_reg;
  logic [31:0]       length_reg;
  logic [31:0]       copied_reg;
  logic [3:0]        ctrl_reg;
  logic              sys_rst_d_reg;

  wire sys_rst_edge  = system_soft_reset & ~sys_rst_d_reg;
  wire soft_req      = sys_rst_edge | ctrl_reg[`CTRL_SOFT_RESET];
  wire word_taken    = src_req & src_rvalid;
  wire copy_last     = (copied_reg + 32'd1) >= length_reg;
  wire len_ok        = (src_rdata != 32'd0) &&
                       (src_rdata <= 32'(OCM_WORDS));

  // One pin pair shorted selects one source; anything else is no source
  wire boot_src_e pin_code =
      (mode_jumper == 3'b001) ? SRC_CARD  :
      (mode_jumper == 3'b010) ? SRC_FLASH :
      (mode_jumper == 3'b100) ? SRC_DEBUG : SRC_NONE;

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_STRAP:    state_next = ST_CLEAR;
      ST_CLEAR: begin
        if (boot_mode_reg == SRC_DEBUG) begin
          state_next = ST_DBG_WAIT;
        end else if (boot_mode_reg == SRC_NONE) begin
          state_next = ST_ERROR;
        end else begin
          state_next = ST_HDR_MARK;
        end
      end
      ST_HDR_MARK: if (word_taken) begin
        state_next = (src_rdata == MARKER) ? ST_HDR_LEN : ST_ERROR;
      end
      ST_HDR_LEN:  if (word_taken) begin
        state_next = len_ok ? ST_HDR_FLAG : ST_ERROR;
      end
      ST_HDR_FLAG: if (word_taken) state_next = ST_COPY;
      ST_COPY:     if (word_taken && copy_last) state_next = ST_HANDOFF;
      ST_HANDOFF:  state_next = ST_PS_INIT;
      ST_PS_INIT:  if (ps_init_done) begin
        state_next = bitstream_reg ? ST_FABRIC : ST_APP_LOAD;
      end
      ST_FABRIC:   if (fabric_cfg_done) state_next = ST_APP_LOAD;
      ST_APP_LOAD: if (app_load_done) state_next = ST_RUNNING;
      ST_RUNNING:  state_next = ST_RUNNING;
      ST_DBG_WAIT: begin
        if (ctrl_reg[`CTRL_HOST_LOADED]) state_next = ST_DBG_HALT;
      end
      ST_DBG_HALT: state_next = ST_DBG_HALT;
      ST_ERROR:    state_next = ST_ERROR;
      default:     state_next = ST_ERROR;
    endcase
    if (soft_req && state_reg != ST_STRAP) begin
      state_next = ST_CLEAR;
    end
  end

  // ----------------------------------------------------------------
  // Strap capture and sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boot_mode_reg <= SRC_NONE;
      split_reg     <= 1'b0;
    end else if (state_reg == ST_STRAP) begin
      // Only reached after power-on; system reset never returns here
      boot_mode_reg <= pin_code;
      split_reg     <= chain_split_jumper;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg     <= ST_STRAP;
      sys_rst_d_reg <= 1'b0;
    end else begin
      state_reg     <= state_next;
      sys_rst_d_reg <= system_soft_reset;
    end
  end

  wire fetch_state = (state_reg == ST_HDR_MARK) ||
                     (state_reg == ST_HDR_LEN)  ||
                     (state_reg == ST_HDR_FLAG) ||
                     (state_reg == ST_COPY);
  wire clearing    = (state_next == ST_CLEAR);

  always_ff @(posedge aclk) begin
    if (!aresetn || clearing) begin
      src_req       <= 1'b0;
      src_addr      <= '0;
      ocm_we        <= 1'b0;
      ocm_addr      <= '0;
      ocm_wdata     <= `WORD_RESET;
      error_reg     <= 1'b0;
      bitstream_reg <= 1'b0;
      length_reg    <= `WORD_RESET;
      copied_reg    <= `WORD_RESET;
    end else begin
      ocm_we  <= 1'b0;
      src_req <= fetch_state && !word_taken && (state_next == state_reg);
      if (word_taken) begin
        src_addr <= src_addr + 1'b1;
        case (state_reg)
          ST_HDR_LEN:  length_reg    <= src_rdata;
          ST_HDR_FLAG: bitstream_reg <= src_rdata[`FLAG_BITSTREAM];
          ST_COPY: begin
            ocm_we     <= 1'b1;
            ocm_addr   <= copied_reg[ADDR_W-1:0];
            ocm_wdata  <= src_rdata;
            copied_reg <= copied_reg + 32'd1;
          end
          default: ;
        endcase
      end
      if (state_next == ST_ERROR) error_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Boot outputs
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_sel              <= 2'(SRC_NONE);
      ocm_clear            <= 1'b0;
      fabric_clear         <= 1'b0;
      handoff              <= 1'b0;
      core_run             <= 1'b0;
      core_step            <= 1'b0;
      ps_init_req          <= 1'b0;
      fabric_cfg_req       <= 1'b0;
      app_load_req         <= 1'b0;
      app_start            <= 1'b0;
      ps_on_scan_chain     <= 1'b1;
      fabric_on_scan_chain <= 1'b1;
    end else begin
      src_sel        <= 2'(boot_mode_reg);
      ocm_clear      <= clearing;
      fabric_clear   <= clearing;
      // Pulse follows the last loader write by one cycle
      handoff        <= (state_reg == ST_HANDOFF);
      ps_init_req    <= (state_next == ST_PS_INIT);
      fabric_cfg_req <= (state_next == ST_FABRIC);
      app_load_req   <= (state_next == ST_APP_LOAD);
      app_start      <= (state_reg == ST_APP_LOAD) &&
                        (state_next == ST_RUNNING);
      // Debug boot: core held until host load, then run or step
      core_run  <= ((state_next != ST_CLEAR) &&
                    (state_next >= ST_PS_INIT) &&
                    (state_next <= ST_RUNNING)) ||
                   ((state_next == ST_DBG_HALT) &&
                    ctrl_reg[`CTRL_FREE_RUN]);
      core_step <= (state_reg == ST_DBG_HALT) &&
                   ctrl_reg[`CTRL_STEP];
      // Fabric is always on the chain, open to host configuration
      fabric_on_scan_chain <= 1'b1;
      ps_on_scan_chain     <= !split_reg;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic              aw_held_reg, w_held_reg;
  logic [7:0]        aw_addr_reg;
  logic [31:0]       w_data_reg;
  logic [3:0]        w_strb_reg;

  wire aw_take   = s_axi_awvalid & s_axi_awready;
  wire w_take    = s_axi_wvalid & s_axi_wready;
  wire wr_fire   = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  wire wr_ctrl   = wr_fire && (aw_addr_reg == `REG_CTRL) && w_strb_reg[0];
  wire wr_map    = (aw_addr_reg == `REG_CTRL)   ||
                   (aw_addr_reg == `REG_STATUS) ||
                   (aw_addr_reg == `REG_LENGTH) ||
                   (aw_addr_reg == `REG_COPIED);
  wire ar_take   = s_axi_arvalid & s_axi_arready;
  wire rd_map    = (s_axi_araddr == `REG_CTRL)   ||
                   (s_axi_araddr == `REG_STATUS) ||
                   (s_axi_araddr == `REG_LENGTH) ||
                   (s_axi_araddr == `REG_COPIED);

  wire [31:0] status_word = {16'h0000,
                             (state_reg == ST_RUNNING),
                             bitstream_reg, split_reg, error_reg,
                             4'h0, 4'(state_reg), 2'b00,
                             2'(boot_mode_reg)};
  wire [31:0] rd_word =
      (s_axi_araddr == `REG_CTRL)   ? {28'h000_0000, ctrl_reg} :
      (s_axi_araddr == `REG_STATUS) ? status_word :
      (s_axi_araddr == `REG_LENGTH) ? length_reg  :
      (s_axi_araddr == `REG_COPIED) ? copied_reg  : `WORD_RESET;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= `WORD_RESET;
      w_strb_reg    <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else begin
      if (aw_take) begin
        aw_held_reg   <= 1'b1;
        aw_addr_reg   <= {s_axi_awaddr[7:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        w_held_reg   <= 1'b1;
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? 2'b00 : 2'b10;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `WORD_RESET;
      s_axi_rresp   <= 2'b00;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_map ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Reset request and step are single-shot; a soft reset drops debug bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= w_data_reg[3:0];
    end else if (soft_req) begin
      ctrl_reg <= `CTRL_RESET;
    end else begin
      ctrl_reg[`CTRL_STEP] <= 1'b0;
    end
  end

endmodule : boot_mode_config_loader
`default_nettype wire

// *** verilog/boot_loader_defs.svh ***
`ifndef BOOT_LOADER_DEFS_SVH
`define BOOT_LOADER_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define REG_CTRL          8'h00
`define REG_STATUS        8'h04
`define REG_LENGTH        8'h08
`define REG_COPIED        8'h0C

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CTRL_SOFT_RESET   0
`define CTRL_HOST_LOADED  1
`define CTRL_FREE_RUN     2
`define CTRL_STEP         3

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define STAT_MODE_LSB     0
`define STAT_STATE_LSB    4
`define STAT_ERROR        12
`define STAT_SPLIT        13
`define STAT_BITSTREAM    14
`define STAT_RUNNING      15

// ----------------------------------------------------------------
// Boot-mode codes and container layout
// ----------------------------------------------------------------
`define MODE_CODE_CARD    2'h0
`define MODE_CODE_FLASH   2'h1
`define MODE_CODE_DEBUG   2'h2
`define MODE_CODE_NONE    2'h3
`define FLAG_BITSTREAM    0
`define OCM_BYTES_DEFAULT 262144
`define MARKER_DEFAULT    32'hA5C3_0F1E

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CTRL_RESET        4'h0
`define WORD_RESET        32'h0000_0000

`endif

// *** verilog/boot_loader_pkg.sv ***
package boot_loader_pkg;

  typedef enum logic [1:0] {
    SRC_CARD,
    SRC_FLASH,
    SRC_DEBUG,
    SRC_NONE
  } boot_src_e;

  typedef enum logic [3:0] {
    ST_STRAP,
    ST_CLEAR,
    ST_HDR_MARK,
    ST_HDR_LEN,
    ST_HDR_FLAG,
    ST_COPY,
    ST_HANDOFF,
    ST_PS_INIT,
    ST_FABRIC,
    ST_APP_LOAD,
    ST_RUNNING,
    ST_DBG_WAIT,
    ST_DBG_HALT,
    ST_ERROR
  } boot_state_e;

endpackage : boot_loader_pkg

// *** tb/boot_mode_config_loader_props.sv ***
`timescale 1ns/100ps
`default_nettype none
module boot_mode_config_loader_props (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       system_soft_reset,
  input wire logic [1:0] src_sel,
  input wire logic       src_req,
  input wire logic       src_rvalid,
  input wire logic       ocm_we,
  input wire logic       ocm_clear,
  input wire logic       fabric_clear,
  input wire logic       handoff,
  input wire logic       ps_init_req,
  input wire logic       fabric_cfg_req,
  input wire logic       app_load_req,
  input wire logic       app_load_done,
  input wire logic       app_start,
  input wire logic       ps_on_scan_chain,
  input wire logic       fabric_on_scan_chain
);
  // Cycles since power-on release, saturating
  logic [1:0] up_cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn)
      up_cnt <= 2'h0;
    else if (up_cnt != 2'h3)
      up_cnt <= up_cnt + 2'h1;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence copy_end_s;
    ocm_we ##1 handoff;
  endsequence
  sequence app_loaded_s;
    app_load_req && app_load_done;
  endsequence
  strap_hold_a: assert property (up_cnt == 2'h3 |->
    $stable(src_sel) && $stable(ps_on_scan_chain))
    else $error("boot mode changed without power-up");
  clear_pair_a: assert property (ocm_clear |-> fabric_clear ##1 !ocm_clear)
    else $error("memory clear not a paired pulse");
  soft_clear_a: assert property (up_cnt == 2'h3 &&
    $rose(system_soft_reset) |-> ##[1:4] ocm_clear)
    else $error("system reset did not clear memories");
  handoff_src_a: assert property (handoff |-> $past(ocm_we))
    else $error("handoff not after last loader word");
  handoff_init_a: assert property (copy_end_s |-> ##[0:1] ps_init_req)
    else $error("setup not started at handoff");
  req_drop_a: assert property (src_req && src_rvalid |=> !src_req)
    else $error("media request held after answer");
  we_after_a: assert property (ocm_we |-> $past(src_rvalid))
    else $error("memory write without media word");
  stage_excl_a: assert property (fabric_cfg_req |->
    !ps_init_req && !app_load_req)
    else $error("fabric stage overlaps another stage");
  app_start_a: assert property (app_loaded_s |-> ##[1:3] app_start)
    else $error("application not started");
  chain_fab_a: assert property (up_cnt != 2'h0 |-> fabric_on_scan_chain)
    else $error("fabric missing from scan chain");
endmodule : boot_mode_config_loader_props
`default_nettype wire

// *** tb/boot_media_model.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "boot_loader_defs.svh"
module boot_media_model #(
  parameter int          LEN    = 16,
  parameter logic [31:0] MARKER = `MARKER_DEFAULT
) (
  input  wire logic        aclk,
  input  wire logic        bitstream,
  input  wire logic        slow,
  input  wire logic        src_req,
  input  wire logic [15:0] src_addr,
  output logic             src_rvalid,
  output logic [31:0]      src_rdata,
  input  wire logic        ps_init_req,
  output logic             ps_init_done,
  input  wire logic        fabric_cfg_req,
  output logic             fabric_cfg_done,
  input  wire logic        app_load_req,
  output logic             app_load_done
);
  logic [2:0] wait_cnt = 3'h0;
  // Loader wrapped in the image container only
  function automatic logic [31:0] image_word(input logic [15:0] a);
    case (a)
      16'h0000: return MARKER;
      16'h0001: return 32'(LEN);
      16'h0002: return {31'h0, bitstream};
      default:  return 32'h1000_0000 + {16'h0000, a};
    endcase
  endfunction
  initial {src_rvalid, src_rdata, ps_init_done} = '0;
  initial {fabric_cfg_done, app_load_done} = '0;
  always @(posedge aclk) begin
    src_rvalid <= 1'b0;
    // Idle data toggles so stale words never look valid
    src_rdata  <= ~src_rdata;
    if (src_req && !src_rvalid) begin
      if (wait_cnt == (slow ? 3'h5 : 3'h0)) begin
        src_rvalid <= 1'b1;
        src_rdata  <= image_word(src_addr);
        wait_cnt   <= 3'h0;
      end else begin
        wait_cnt <= wait_cnt + 3'h1;
      end
    end
    ps_init_done    <= ps_init_req && !ps_init_done;
    fabric_cfg_done <= fabric_cfg_req && !fabric_cfg_done;
    app_load_done   <= app_load_req && !app_load_done;
  end
endmodule : boot_media_model
`default_nettype wire

// *** tb/boot_mode_config_loader_test.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "boot_loader_defs.svh"
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin \
  failures++; $display("Error %s expected %h seen %h", nm, exp, got); end end
module boot_mode_config_loader_test;
  import boot_loader_pkg::*;
  localparam int LEN = 16;
  logic aclk = 1'b0, aresetn = 1'b0, chain_split_jumper = 1'b0;
  logic system_soft_reset = 1'b0, bitstream = 1'b1, slow = 1'b0;
  logic [2:0]  mode_jumper = 3'b001;
  logic [1:0]  src_sel, s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0] src_addr, ocm_addr, last_addr;
  logic [31:0] src_rdata, ocm_wdata, s_axi_rdata, rd;
  logic src_req, src_rvalid, ocm_we, ocm_clear, fabric_clear, handoff;
  logic core_run, core_step, ps_init_req, ps_init_done, fabric_cfg_req;
  logic fabric_cfg_done, app_load_req, app_load_done, app_start;
  logic ps_on_scan_chain, fabric_on_scan_chain, s_axi_awready;
  logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic seen_clr, seen_hand, seen_fab, seen_step, seen_app, seen_req;
  int failures = 0, tests_run = 0, cyc = 0, n_we, bad_wr;

  boot_mode_config_loader #(.OCM_BYTES(4 * LEN)) boot_mode_config_loader_inst (.*);
  boot_media_model #(.LEN(LEN)) boot_media_model_inst (.*);

  always #20 aclk = ~aclk;

  // ----------------------------------------
  // Monitor and timeout
  // ----------------------------------------
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      stop_test();
    end
    if (!aresetn || system_soft_reset) begin
      n_we = 0;
      bad_wr = 0;
      {seen_clr, seen_hand, seen_fab, seen_step, seen_app, seen_req} = '0;
    end else begin
      if (ocm_we) begin
        n_we++;
        last_addr = ocm_addr;
        if (ocm_wdata !== 32'h1000_0003 + {16'h0000, ocm_addr}) bad_wr++;
      end
      {seen_clr, seen_hand, seen_fab, seen_step, seen_app, seen_req} |=
        {ocm_clear, handoff, fabric_cfg_req, core_step, app_start, src_req};
    end
  end

  // ----------------------------------------
  // Bus and sequencing helpers
  // ----------------------------------------
  task automatic stop_test();
    $display("Checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task automatic power_up(input logic [2:0] j, input logic sp);
    aresetn <= 1'b0;
    mode_jumper <= j;
    chain_split_jumper <= sp;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : power_up

  task automatic wait_app();
    // Ends once seen_app is set; only the global timeout bounds this wait
    while (!seen_app) begin
      @(posedge aclk);
    end
  endtask : wait_app

  task automatic t_card();
    bitstream <= 1'b1;
    slow <= 1'b0;
    power_up(3'b001, 1'b0);
    wait_app();
    `CHK("src_sel", SRC_CARD, src_sel)
    `CHK("words", LEN, n_we)
    `CHK("last_addr", 16'(LEN - 1), last_addr)
    `CHK("bad_words", 0, bad_wr)
    `CHK("handoff", 1'b1, seen_hand)
    `CHK("fabric_cfg", 1'b1, seen_fab)
    `CHK("chain", 2'b11, {ps_on_scan_chain, fabric_on_scan_chain})
    axi_rd(`REG_STATUS, rd, rsp);
    `CHK("status", {2'b11, ST_RUNNING, SRC_CARD}, {rd[15:14], rd[7:4], rd[1:0]})
  endtask : t_card

  task automatic t_flash_reset();
    bitstream <= 1'b0;
    slow <= 1'b1;
    power_up(3'b010, 1'b0);
    wait_app();
    `CHK("src_sel", SRC_FLASH, src_sel)
    `CHK("fabric_cfg", 1'b0, seen_fab)
    mode_jumper <= 3'b100;
    system_soft_reset <= 1'b1;
    @(posedge aclk);
    system_soft_reset <= 1'b0;
    repeat (8) @(posedge aclk);
    `CHK("restart_clear", 1'b1, seen_clr)
    wait_app();
    `CHK("mode_kept", SRC_FLASH, src_sel)
    `CHK("words", LEN, n_we)
  endtask : t_flash_reset

  task automatic t_debug();
    power_up(3'b100, 1'b1);
    repeat (30) @(posedge aclk);
    `CHK("src_sel", SRC_DEBUG, src_sel)
    `CHK("chain", 2'b01, {ps_on_scan_chain, fabric_on_scan_chain})
    `CHK("stalled", 2'b00, {core_run, seen_req})
    axi_wr(`REG_CTRL, 32'h0000_0002);
    axi_wr(`REG_CTRL, 32'h0000_000A);
    repeat (4) @(posedge aclk);
    `CHK("step", 2'b01, {core_run, seen_step})
    axi_wr(`REG_CTRL, 32'h0000_0006);
    repeat (4) @(posedge aclk);
    `CHK("free_run", 1'b1, core_run)
  endtask : t_debug

  task automatic t_bad();
    power_up(3'b011, 1'b0);
    repeat (20) @(posedge aclk);
    `CHK("src_sel", SRC_NONE, src_sel)
    axi_rd(`REG_STATUS, rd, rsp);
    `CHK("error", 1'b1, rd[12])
    axi_rd(8'h10, rd, rsp);
    `CHK("unmapped", 34'h2_0000_0000, {rsp, rd})
  endtask : t_bad

  initial begin
    t_card();
    t_flash_reset();
    t_debug();
    t_bad();
    stop_test();
  end
endmodule : boot_mode_config_loader_test

bind boot_mode_config_loader boot_mode_config_loader_props props_inst (.*);
`default_nettype wire
